// [rtl/ignition_timing_angle_calc.sv]
module ignition_timing_angle_calc #(
	parameter int KNOB_W   = 10,
	parameter int ANALOG_W = 10
) (
	// Clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 nrst,
	// Wishbone slave
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [7:0]           wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic      [31:0]          wb_dat_o,
	output logic                      wb_ack_o,
	// Sensor inputs
	input  wire logic [KNOB_W-1:0]    knobPos,
	input  wire logic [ANALOG_W-1:0]  analogLevel,
	input  wire logic [15:0]          engineSpeed,
	input  wire logic                 contactIn,
	// Results
	output logic      [15:0]          fireAngle,
	output logic                      angleValid,
	output logic                      activeSchedule,
	output logic      [6:0]           energyLevel
);
	localparam int NW = ign_timing_pkg::NUM_W;
	localparam int DW = ign_timing_pkg::DEN_W;
	localparam logic [DW-1:0] KNOB_FULL = DW'((1 << KNOB_W) - 1);
	localparam logic [DW-1:0] ANA_FULL  = DW'((1 << ANALOG_W) - 1);
	localparam ign_timing_pkg::calc_state_e S_IDLE =
		ign_timing_pkg::S_IDLE;
	localparam ign_timing_pkg::calc_state_e S_POT =
		ign_timing_pkg::S_POT;
	localparam ign_timing_pkg::calc_state_e S_ANA =
		ign_timing_pkg::S_ANA;
	localparam ign_timing_pkg::calc_state_e S_CRV =
		ign_timing_pkg::S_CRV;
	localparam ign_timing_pkg::calc_state_e S_SUM =
		ign_timing_pkg::S_SUM;

	logic [31:0] cfgMem [0:31];
	logic [31:0] ctrl_ff, nxt_ctrl;
	logic [6:0]  energy_ff, nxt_energy;
	logic        wbAck_ff, nxt_wbAck;
	logic [31:0] wbDat_ff, nxt_wbDat;
	logic        wrTake;
	logic [4:0]  wrIdx;
	logic        wrHit;
	logic [31:0] wrWord;

	ign_timing_pkg::calc_state_e state_ff, nxt_state;
	logic              sched_ff, nxt_sched;
	logic signed [17:0] potTerm_ff, nxt_potTerm;
	logic signed [17:0] anaTerm_ff, nxt_anaTerm;
	logic signed [17:0] crvTerm_ff, nxt_crvTerm;
	logic signed [15:0] fire_ff, nxt_fire;
	logic              valid_ff, nxt_valid;
	logic [KNOB_W-1:0] knobHeld_ff, nxt_knobHeld;
	logic [KNOB_W-1:0] knobUse;

	logic                  divStart, divDone;
	logic signed [NW-1:0]  divNum, divQuot;
	logic        [DW-1:0]  divDen;
	logic signed [15:0]    opBase, crvBase;
	logic signed [NW-1:0]  crvNum;
	logic        [DW-1:0]  crvDen;
	logic signed [17:0]    stepTerm;
	logic signed [19:0]    sum;
	logic signed [15:0]    maxAdv, maxRet;
	logic                  curveEn, anaEn;
	logic [2:0]            bpCount;
	int                    seg;
	logic [31:0]           enWord;
	logic signed [15:0]    base_ff, nxt_base;

	function automatic logic [31:0] selMask(input logic [3:0] sel);
		selMask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction : selMask

	function automatic logic [31:0] fieldMask(input logic [3:0] w);
		if (w == ign_timing_pkg::W_ENABLES)
			fieldMask = ign_timing_pkg::ENABLES_MASK;
		else if (w >= ign_timing_pkg::W_BP_FIRST
			&& w <= ign_timing_pkg::W_BP_LAST)
			fieldMask = 32'hffff_ffff;
		else if (w <= ign_timing_pkg::W_MAX_RET)
			fieldMask = ign_timing_pkg::ANGLE_MASK;
		else
			fieldMask = 32'h0000_0000;
	endfunction : fieldMask

	function automatic logic [31:0] cfgWord(input logic s,
		input logic [3:0] w);
		cfgWord = cfgMem[{s, w}];
	endfunction : cfgWord

	function automatic logic signed [NW-1:0] scaleNum(
		input logic signed [15:0] a0, input logic signed [15:0] a1,
		input logic signed [17:0] dx);
		logic signed [16:0] d;
		d = 17'($signed(a1)) - 17'($signed(a0));
		scaleNum = NW'(d * dx);
	endfunction : scaleNum

	// Wishbone slave and configuration store
	assign wrTake = wb_cyc_i && wb_stb_i && wbAck_ff && wb_we_i;
	assign wrIdx  = {wb_adr_i[7], wb_adr_i[5:2]};
	assign wrHit  = wb_adr_i[7:6] == ign_timing_pkg::REGION_SCHED_A
		|| wb_adr_i[7:6] == ign_timing_pkg::REGION_SCHED_B;

	always_comb
	begin
		nxt_wbAck  = wb_cyc_i && wb_stb_i && !wbAck_ff;
		nxt_wbDat  = 32'h0000_0000;
		nxt_ctrl   = ctrl_ff;
		nxt_energy = energy_ff;
		wrWord = (cfgMem[wrIdx] & ~selMask(wb_sel_i))
			| (wb_dat_i & selMask(wb_sel_i));
		wrWord = wrWord & fieldMask(wb_adr_i[5:2]);
		if (wb_adr_i[5:2] == ign_timing_pkg::W_ENABLES
			&& wrWord[ign_timing_pkg::BP_COUNT_LSB +: 3]
			> 3'(ign_timing_pkg::MAX_BREAKPOINTS))
			wrWord[ign_timing_pkg::BP_COUNT_LSB +: 3] =
				3'(ign_timing_pkg::MAX_BREAKPOINTS);
		if (wb_cyc_i && wb_stb_i && !wbAck_ff)
		begin
			if (wrHit)
				nxt_wbDat = cfgMem[wrIdx];
			else if (wb_adr_i == ign_timing_pkg::REG_CTRL)
				nxt_wbDat = ctrl_ff;
			else if (wb_adr_i == ign_timing_pkg::REG_ENERGY)
				nxt_wbDat = {25'h0, energy_ff};
			else if (wb_adr_i == ign_timing_pkg::REG_STATUS)
				nxt_wbDat = {14'h0, state_ff != S_IDLE, sched_ff,
					fire_ff};
		end
		if (wrTake && wb_adr_i == ign_timing_pkg::REG_CTRL)
			nxt_ctrl = ((ctrl_ff & ~selMask(wb_sel_i))
				| (wb_dat_i & selMask(wb_sel_i)))
				& ign_timing_pkg::CTRL_MASK;
		if (wrTake && wb_adr_i == ign_timing_pkg::REG_ENERGY
			&& wb_sel_i[0])
		begin
			if (wb_dat_i[7:0] < {1'b0, ign_timing_pkg::ENERGY_MIN})
				nxt_energy = ign_timing_pkg::ENERGY_MIN;
			else if (wb_dat_i[7:0] > {1'b0, ign_timing_pkg::ENERGY_MAX})
				nxt_energy = ign_timing_pkg::ENERGY_MAX;
			else
				nxt_energy = wb_dat_i[6:0];
		end
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wbAck_ff  <= 1'b0;
			wbDat_ff  <= 32'h0000_0000;
			ctrl_ff   <= ign_timing_pkg::CTRL_RESET;
			energy_ff <= ign_timing_pkg::ENERGY_RESET;
			for (int i = 0; i < 32; i++)
				cfgMem[i] <= ign_timing_pkg::CFG_RESET;
		end
		else
		begin
			wbAck_ff  <= nxt_wbAck;
			wbDat_ff  <= nxt_wbDat;
			ctrl_ff   <= nxt_ctrl;
			energy_ff <= nxt_energy;
			if (wrTake && wrHit)
				cfgMem[wrIdx] <= wrWord;
		end
	end

	// Active schedule fields
	assign enWord = cfgWord(sched_ff, ign_timing_pkg::W_ENABLES);
	assign curveEn = enWord[ign_timing_pkg::EN_CURVE_BIT];
	assign anaEn = enWord[ign_timing_pkg::EN_ANALOG_BIT];
	assign bpCount = enWord[ign_timing_pkg::BP_COUNT_LSB +: 3];
	assign maxAdv = 16'(cfgWord(sched_ff, ign_timing_pkg::W_MAX_ADV));
	assign maxRet = 16'(cfgWord(sched_ff, ign_timing_pkg::W_MAX_RET));
	assign knobUse = ctrl_ff[ign_timing_pkg::CTRL_POT_EN_BIT]
		? knobPos : knobHeld_ff;

	// Curve segment search and interpolation operands
	always_comb
	begin
		logic [31:0] lo, hi;
		lo  = 32'h0000_0000;
		hi  = 32'h0000_0000;
		seg = 0;
		for (int i = 0; i < ign_timing_pkg::MAX_BREAKPOINTS; i++)
		begin
			lo = cfgWord(sched_ff, 4'(ign_timing_pkg::W_BP_FIRST + i));
			if (i < int'(bpCount) && engineSpeed >=
				lo[ign_timing_pkg::BP_SPEED_LSB +: 16])
				seg = i;
		end
		lo = cfgWord(sched_ff, 4'(ign_timing_pkg::W_BP_FIRST + seg));
		hi = cfgWord(sched_ff, 4'(ign_timing_pkg::W_BP_FIRST + seg + 1));
		crvBase = lo[15:0];
		crvNum  = '0;
		crvDen  = DW'(1);
		if (!curveEn || bpCount == 3'h0)
			crvBase = 16'sh0000;
		else if (seg + 1 < int'(bpCount) && engineSpeed >=
			lo[ign_timing_pkg::BP_SPEED_LSB +: 16]
			&& hi[31:16] > lo[31:16])
		begin
			crvNum = scaleNum(lo[15:0], hi[15:0],
				18'(engineSpeed - lo[31:16]));
			crvDen = DW'(hi[31:16] - lo[31:16]);
		end
	end

	// Operand feed to the shared divider
	always_comb
	begin
		opBase = 16'sh0000;
		divNum = '0;
		divDen = DW'(1);
		case (state_ff)
			S_IDLE:
			begin
				opBase = 16'(cfgWord(nxt_sched,
					ign_timing_pkg::W_KNOB_LEFT));
				divNum = scaleNum(opBase,
					16'(cfgWord(nxt_sched, ign_timing_pkg::W_KNOB_RIGHT)),
					18'(knobUse));
				divDen = KNOB_FULL;
			end
			S_POT:
			begin
				opBase = 16'(cfgWord(sched_ff,
					ign_timing_pkg::W_ANA_LOW));
				divNum = scaleNum(opBase,
					16'(cfgWord(sched_ff, ign_timing_pkg::W_ANA_HIGH)),
					18'(analogLevel));
				divDen = ANA_FULL;
			end
			S_ANA:
			begin
				opBase = crvBase;
				divNum = crvNum;
				divDen = crvDen;
			end
			default:
			begin
				opBase = 16'sh0000;
			end
		endcase
	end

	// Base held from divide start, operands move on meanwhile
	assign stepTerm = 18'(base_ff) + 18'(divQuot);
	assign sum = 20'(potTerm_ff) + 20'(crvTerm_ff)
		+ (anaEn ? 20'(anaTerm_ff) : 20'sh00000);

	// Calculation sequencer
	always_comb
	begin
		nxt_state    = state_ff;
		nxt_sched    = ctrl_ff[ign_timing_pkg::CTRL_CONTACT_AB_BIT]
			? contactIn : 1'b0;
		nxt_potTerm  = potTerm_ff;
		nxt_anaTerm  = anaTerm_ff;
		nxt_crvTerm  = crvTerm_ff;
		nxt_fire     = fire_ff;
		nxt_valid    = valid_ff;
		nxt_knobHeld = ctrl_ff[ign_timing_pkg::CTRL_POT_EN_BIT]
			? knobPos : knobHeld_ff;
		divStart     = 1'b0;
		if (state_ff != S_IDLE)
			nxt_sched = sched_ff;
		case (state_ff)
			S_IDLE:
			begin
				divStart  = 1'b1;
				nxt_state = S_POT;
			end
			S_POT:
				if (divDone)
				begin
					nxt_potTerm = stepTerm;
					divStart    = 1'b1;
					nxt_state   = S_ANA;
				end
			S_ANA:
				if (divDone)
				begin
					nxt_anaTerm = stepTerm;
					divStart    = 1'b1;
					nxt_state   = S_CRV;
				end
			S_CRV:
				if (divDone)
				begin
					nxt_crvTerm = stepTerm;
					nxt_state   = S_SUM;
				end
			S_SUM:
			begin
				if (engineSpeed == 16'h0000)
					nxt_fire = potTerm_ff[15:0];
				else if (sum > 20'(maxAdv))
					nxt_fire = maxAdv;
				else if (sum < 20'(maxRet))
					nxt_fire = maxRet;
				else
					nxt_fire = sum[15:0];
				nxt_valid = 1'b1;
				nxt_state = S_IDLE;
			end
			default:
				nxt_state = S_IDLE;
		endcase
		nxt_base = divStart ? opBase : base_ff;
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_ff    <= S_IDLE;
			sched_ff    <= 1'b0;
			potTerm_ff  <= 18'sh00000;
			anaTerm_ff  <= 18'sh00000;
			crvTerm_ff  <= 18'sh00000;
			fire_ff     <= 16'sh0000;
			valid_ff    <= 1'b0;
			knobHeld_ff <= '0;
			base_ff     <= 16'sh0000;
		end
		else
		begin
			state_ff    <= nxt_state;
			sched_ff    <= nxt_sched;
			potTerm_ff  <= nxt_potTerm;
			anaTerm_ff  <= nxt_anaTerm;
			crvTerm_ff  <= nxt_crvTerm;
			fire_ff     <= nxt_fire;
			valid_ff    <= nxt_valid;
			knobHeld_ff <= nxt_knobHeld;
			base_ff     <= nxt_base;
		end
	end

	interp_div #(.NW(NW), .DW(DW)) divider (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.start   (divStart),
		.num     (divNum),
		.den     (divDen),
		.done    (divDone),
		.quot    (divQuot)
	);

	assign wb_ack_o       = wbAck_ff;
	assign wb_dat_o       = wbDat_ff;
	assign fireAngle      = fire_ff;
	assign angleValid     = valid_ff;
	assign activeSchedule = sched_ff;
	assign energyLevel    = energy_ff;

	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	advLimit_a: assert property ((state_ff == S_SUM && engineSpeed != 0
		&& maxRet <= maxAdv) |=> $signed(fire_ff) <= $past(maxAdv))
		else $error("fire angle above advance limit");
	retLimit_a: assert property ((state_ff == S_SUM && engineSpeed != 0
		&& maxRet <= maxAdv) |=> $signed(fire_ff) >= $past(maxRet))
		else $error("fire angle below retard limit");
	stoppedKnob_a: assert property ((state_ff == S_SUM
		&& engineSpeed == 0) |=> fire_ff == $past(potTerm_ff[15:0]))
		else $error("stopped engine angle is not knob term");
	energyRange_a: assert property (energy_ff >= ign_timing_pkg::ENERGY_MIN
		&& energy_ff <= ign_timing_pkg::ENERGY_MAX)
		else $error("energy level out of range");
	bpCount_a: assert property (
		bpCount <= 3'(ign_timing_pkg::MAX_BREAKPOINTS))
		else $error("breakpoint count above five");
	knobFreeze_a: assert property (
		!ctrl_ff[ign_timing_pkg::CTRL_POT_EN_BIT] [*2]
		|-> $stable(knobHeld_ff))
		else $error("held knob moved while disabled");
	curveOff_a: assert property ((state_ff == S_CRV && divDone
		&& !curveEn) |=> crvTerm_ff == 18'sh00000)
		else $error("disabled curve contributes");
	schedPick_a: assert property ((state_ff == S_IDLE
		&& ctrl_ff[ign_timing_pkg::CTRL_CONTACT_AB_BIT])
		|=> sched_ff == $past(contactIn))
		else $error("schedule not taken from contact");
	calcRound_a: assert property ((state_ff == S_IDLE)
		|-> ##[1:140] state_ff == S_SUM)
		else $error("calculation round too long");

	stopped_c: cover property (state_ff == S_SUM && engineSpeed == 0);
	schedB_c: cover property (state_ff == S_SUM && sched_ff);
	clampAdv_c: cover property (state_ff == S_SUM && sum > 20'(maxAdv));
	curveOn_c: cover property (state_ff == S_CRV && divDone && curveEn);
endmodule : ignition_timing_angle_calc

// [include/ign_timing_pkg.sv]
// Contract
// - Each schedule has own curve, enable gates it
// - Per schedule enable for analog offset
// - Stored angle at knob left end stop
// - Stored angle at knob right end stop
// - Clamp sum to schedule advance limit
// - Clamp sum to schedule retard limit
// - Signed analog term added to sum
// - Stored signed offset at lowest input
// - Stored signed offset at highest input
// - Analog offset linear across input range
// - Breakpoint count programmable, five at most
// - Breakpoint holds speed and signed angle
// - Stopped engine reports knob term alone
// - Energy level limited to twenty..hundred percent
// - Contact input selects active schedule
// - Knob disable freezes knob contribution
package ign_timing_pkg;
	localparam int ANGLE_W = 16;
	localparam int SPEED_W = 16;
	localparam int NUM_W   = 40;
	localparam int DEN_W   = 17;
	localparam int MAX_BREAKPOINTS = 5;

	// Global word byte offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_ENERGY = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	// Schedule regions, selected by adr[7:6]
	localparam logic [1:0] REGION_GLOBAL = 2'h0;
	localparam logic [1:0] REGION_SCHED_A = 2'h1;
	localparam logic [1:0] REGION_SCHED_B = 2'h2;
	// Word index inside a schedule region
	localparam logic [3:0] W_ENABLES    = 4'h0;
	localparam logic [3:0] W_KNOB_LEFT  = 4'h1;
	localparam logic [3:0] W_KNOB_RIGHT = 4'h2;
	localparam logic [3:0] W_ANA_LOW    = 4'h3;
	localparam logic [3:0] W_ANA_HIGH   = 4'h4;
	localparam logic [3:0] W_MAX_ADV    = 4'h5;
	localparam logic [3:0] W_MAX_RET    = 4'h6;
	localparam logic [3:0] W_BP_FIRST   = 4'h8;
	localparam logic [3:0] W_BP_LAST    = 4'hc;

	// Field layouts
	localparam int EN_CURVE_BIT  = 0;
	localparam int EN_ANALOG_BIT = 1;
	localparam int BP_COUNT_LSB  = 4;
	localparam int BP_COUNT_W    = 3;
	localparam int CTRL_POT_EN_BIT = 0;
	localparam int CTRL_CONTACT_AB_BIT = 1;
	localparam int STAT_SCHED_BIT = 16;
	localparam int STAT_BUSY_BIT  = 17;
	localparam int BP_SPEED_LSB   = 16;

	localparam logic [31:0] ENABLES_MASK = 32'h0000_0073;
	localparam logic [31:0] ANGLE_MASK   = 32'h0000_ffff;
	localparam logic [31:0] CTRL_MASK    = 32'h0000_0003;
	localparam logic [31:0] CTRL_RESET   = 32'h0000_0001;
	localparam logic [31:0] CFG_RESET    = 32'h0000_0000;

	localparam logic [6:0] ENERGY_MIN   = 7'h14;
	localparam logic [6:0] ENERGY_MAX   = 7'h64;
	localparam logic [6:0] ENERGY_RESET = 7'h64;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_POT  = 3'b001,
		S_ANA  = 3'b011,
		S_CRV  = 3'b010,
		S_SUM  = 3'b110
	} calc_state_e;
endpackage : ign_timing_pkg

// [rtl/interp_div.sv]
module interp_div #(
	parameter int NW = 40,
	parameter int DW = 17
) (
	// Clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 nrst,
	// Request
	input  wire logic                 start,
	input  wire logic signed [NW-1:0] num,
	input  wire logic        [DW-1:0] den,
	// Answer
	output logic                      done,
	output logic signed      [NW-1:0] quot
);
	logic          busy_ff, nxt_busy;
	logic          neg_ff, nxt_neg;
	logic          done_ff, nxt_done;
	logic [6:0]    cnt_ff, nxt_cnt;
	logic [DW:0]   rem_ff, nxt_rem;
	logic [NW-1:0] quo_ff, nxt_quo;
	logic [DW-1:0] den_ff, nxt_den;
	logic [DW:0]   trial;

	// Restoring division, one bit per cycle
	always_comb
	begin
		nxt_busy = busy_ff;
		nxt_neg  = neg_ff;
		nxt_done = 1'b0;
		nxt_cnt  = cnt_ff;
		nxt_rem  = rem_ff;
		nxt_quo  = quo_ff;
		nxt_den  = den_ff;
		trial    = {rem_ff[DW-1:0], quo_ff[NW-1]};
		if (start)
		begin
			nxt_busy = 1'b1;
			nxt_neg  = num[NW-1];
			nxt_quo  = num[NW-1] ? NW'(-num) : num;
			nxt_rem  = '0;
			nxt_den  = den;
			nxt_cnt  = 7'(NW);
		end
		else if (busy_ff)
		begin
			if (trial >= {1'b0, den_ff})
			begin
				nxt_rem = trial - {1'b0, den_ff};
				nxt_quo = {quo_ff[NW-2:0], 1'b1};
			end
			else
			begin
				nxt_rem = trial;
				nxt_quo = {quo_ff[NW-2:0], 1'b0};
			end
			nxt_cnt = cnt_ff - 7'h01;
			if (cnt_ff == 7'h01)
			begin
				nxt_busy = 1'b0;
				nxt_done = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			busy_ff <= 1'b0;
			neg_ff  <= 1'b0;
			done_ff <= 1'b0;
			cnt_ff  <= 7'h00;
			rem_ff  <= '0;
			quo_ff  <= '0;
			den_ff  <= '0;
		end
		else
		begin
			busy_ff <= nxt_busy;
			neg_ff  <= nxt_neg;
			done_ff <= nxt_done;
			cnt_ff  <= nxt_cnt;
			rem_ff  <= nxt_rem;
			quo_ff  <= nxt_quo;
			den_ff  <= nxt_den;
		end
	end

	assign done = done_ff;
	assign quot = neg_ff ? NW'(-$signed(quo_ff)) : $signed(quo_ff);
endmodule : interp_div

// [sim/sensor_side_model.sv]
module sensor_side_model (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	// Requested sensor state
	input  wire logic [9:0]  setKnob,
	input  wire logic [9:0]  setLevel,
	input  wire logic [15:0] setSpeed,
	input  wire logic        setContact,
	// Converted sensor outputs
	output logic      [9:0]  knobPos,
	output logic      [9:0]  analogLevel,
	output logic      [15:0] engineSpeed,
	output logic             contactIn
);
	timeunit 1ns;
	timeprecision 1ps;
	// Converters refresh once per clock
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			knobPos     <= 10'h000;
			analogLevel <= 10'h000;
			engineSpeed <= 16'h0000;
			contactIn   <= 1'b0;
		end
		else
		begin
			knobPos     <= setKnob;
			analogLevel <= setLevel;
			engineSpeed <= setSpeed;
			contactIn   <= setContact;
		end
	end
endmodule : sensor_side_model

// [sim/ignition_timing_angle_calc_tb.sv]
module ignition_timing_angle_calc_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk = 1'b0;
	logic        nrst = 1'b0;
	logic        wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
	logic [7:0]  wbAdr = 8'h00;
	logic [3:0]  wbSel = 4'h0;
	logic [31:0] wbDatI = 32'h0, wbDatO, q;
	logic [9:0]  setKnob = 10'h0, setLevel = 10'h0, knobPos, analogLevel;
	logic [15:0] setSpeed = 16'h0, engineSpeed, fireAngle;
	logic        setContact = 1'b0, contactIn, angleValid, activeSchedule;
	logic [6:0]  energyLevel;
	int          n_errors = 0, samples_checked = 0, cycles = 0;
	int          kl[2], kr[2], alo[2], ahi[2], mx[2], mn[2];
	int          cv[2], an[2], nb[2], bs[2][5], ba[2][5];
	int          p, l, v, i;
	logic [6:0]  ein[4] = '{7'h05, 7'h7f, 7'h32, 7'h14};
	always #2 ref_clk = ~ref_clk;
	ignition_timing_angle_calc #(.KNOB_W(10), .ANALOG_W(10)) dut (
		.ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
		.wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
		.wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
		.knobPos(knobPos), .analogLevel(analogLevel),
		.engineSpeed(engineSpeed), .contactIn(contactIn),
		.fireAngle(fireAngle), .angleValid(angleValid),
		.activeSchedule(activeSchedule), .energyLevel(energyLevel));
	sensor_side_model far (
		.ref_clk(ref_clk), .nrst(nrst), .setKnob(setKnob),
		.setLevel(setLevel), .setSpeed(setSpeed), .setContact(setContact),
		.knobPos(knobPos), .analogLevel(analogLevel),
		.engineSpeed(engineSpeed), .contactIn(contactIn));
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			n_errors++;
			wrap_up();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic xfer(input logic we, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s, output logic [31:0] r);
		@(posedge ref_clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= a;
		wbDatI <= d;
		wbSel <= s;
		do
			@(posedge ref_clk);
		while (wbAck !== 1'b1);
		r = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask : xfer
	function automatic logic [7:0] ra(int s, logic [3:0] w);
		return (s != 0 ? 8'h80 : 8'h40) + {2'b00, w, 2'b00};
	endfunction : ra
	function automatic int calc(int s, int p, int l, int v);
		int k, c, a, t, j;
		k = kl[s] + ((kr[s] - kl[s]) * p) / 1023;
		if (v == 0)
			return k;
		c = 0;
		if (cv[s] != 0)
		begin
			c = ba[s][nb[s] - 1];
			for (j = nb[s] - 1; j > 0; j--)
				if (v <= bs[s][j])
					c = ba[s][j - 1] + ((ba[s][j] - ba[s][j - 1])
						* (v - bs[s][j - 1])) / (bs[s][j] - bs[s][j - 1]);
			if (v <= bs[s][0])
				c = ba[s][0];
		end
		a = an[s] != 0 ? alo[s] + ((ahi[s] - alo[s]) * l) / 1023 : 0;
		t = k + c + a;
		if (t > mx[s])
			t = mx[s];
		else if (t < mn[s])
			t = mn[s];
		return t;
	endfunction : calc
	task automatic cfg(int s);
		xfer(1'b1, ra(s, ign_timing_pkg::W_ENABLES),
			32'(cv[s] + 2 * an[s] + 16 * nb[s]), 4'hf, q);
		xfer(1'b1, ra(s, ign_timing_pkg::W_KNOB_LEFT), kl[s] & 'hffff, 4'hf, q);
		xfer(1'b1, ra(s, ign_timing_pkg::W_KNOB_RIGHT), kr[s] & 'hffff, 4'hf, q);
		xfer(1'b1, ra(s, ign_timing_pkg::W_ANA_LOW), alo[s] & 'hffff, 4'hf, q);
		xfer(1'b1, ra(s, ign_timing_pkg::W_ANA_HIGH), ahi[s] & 'hffff, 4'hf, q);
		xfer(1'b1, ra(s, ign_timing_pkg::W_MAX_ADV), mx[s] & 'hffff, 4'hf, q);
		xfer(1'b1, ra(s, ign_timing_pkg::W_MAX_RET), mn[s] & 'hffff, 4'hf, q);
		for (int j = 0; j < 5; j++)
			xfer(1'b1, ra(s, ign_timing_pkg::W_BP_FIRST + 4'(j)),
				{16'(bs[s][j]), 16'(ba[s][j])}, 4'hf, q);
		xfer(1'b0, ra(s, ign_timing_pkg::W_KNOB_LEFT), 32'h0, 4'hf, q);
		chk(q, kl[s] & 'hffff);
		xfer(1'b0, ra(s, ign_timing_pkg::W_KNOB_RIGHT), 32'h0, 4'hf, q);
		chk(q, kr[s] & 'hffff);
	endtask : cfg
	task automatic run(int p, int l, int v, int c, int s, int e);
		@(posedge ref_clk);
		setKnob <= 10'(p);
		setLevel <= 10'(l);
		setSpeed <= 16'(v);
		setContact <= c[0];
		repeat (300) @(posedge ref_clk);
		chk({16'h0000, fireAngle}, {16'h0000, 16'(e)});
		chk({31'h0, activeSchedule}, 32'(s));
	endtask : run
	initial
	begin
		kl = '{2200, 1000}; kr = '{1800, 1000}; alo = '{0, 300};
		ahi = '{-500, 300}; mx = '{2000, 1500}; mn = '{500, -3000};
		cv = '{1, 0}; an = '{1, 0}; nb = '{3, 2};
		bs = '{'{0, 50, 1000, 2000, 3000}, '{0, 100, 0, 0, 0}};
		ba = '{'{0, -1500, 0, 0, 0}, '{900, 900, 0, 0, 0}};
		void'($urandom(32'h9ca66b3e));
		repeat (6) @(posedge ref_clk);
		nrst <= 1'b1;
		xfer(1'b0, ign_timing_pkg::REG_CTRL, 32'h0, 4'hf, q);
		chk(q, ign_timing_pkg::CTRL_RESET);
		xfer(1'b0, ign_timing_pkg::REG_ENERGY, 32'h0, 4'hf, q);
		chk(q, 32'h64);
		xfer(1'b0, ra(0, ign_timing_pkg::W_ENABLES), 32'h0, 4'hf, q);
		chk(q, 32'h0);
		$display("test reset done");
		foreach (ein[k])
		begin
			xfer(1'b1, ign_timing_pkg::REG_ENERGY, {25'h0, ein[k]}, 4'hf, q);
			xfer(1'b0, ign_timing_pkg::REG_ENERGY, 32'h0, 4'hf, q);
			v = ein[k] < 7'h14 ? 32'h14 : ein[k] > 7'h64 ? 32'h64 : ein[k];
			chk(q, v);
			chk({25'h0, energyLevel}, v);
		end
		xfer(1'b1, ign_timing_pkg::REG_ENERGY, 32'h20, 4'he, q);
		xfer(1'b0, ign_timing_pkg::REG_ENERGY, 32'h0, 4'hf, q);
		chk(q, 32'h14);
		$display("test energy done");
		xfer(1'b1, ra(0, ign_timing_pkg::W_ENABLES), 32'h73, 4'hf, q);
		xfer(1'b0, ra(0, ign_timing_pkg::W_ENABLES), 32'h0, 4'hf, q);
		chk(q, 32'h53);
		cfg(0);
		cfg(1);
		for (i = 0; i < 3; i++)
		begin
			p = $urandom_range(1023);
			run(p, $urandom_range(1023), 0, 0, 0, calc(0, p, 0, 0));
		end
		chk({31'h0, angleValid}, 32'h1);
		$display("test stopped engine done");
		run(0, 0, 2000, 0, 0, calc(0, 0, 0, 2000));
		run(1023, 1023, 50, 0, 0, calc(0, 1023, 1023, 50));
		for (i = 0; i < 6; i++)
		begin
			p = $urandom_range(1023);
			l = $urandom_range(1023);
			v = $urandom_range(1500, 1);
			run(p, l, v, 0, 0, calc(0, p, l, v));
		end
		$display("test schedule A done");
		xfer(1'b1, ign_timing_pkg::REG_CTRL, 32'h3, 4'hf, q);
		run(p, l, 500, 1, 1, calc(1, p, l, 500));
		run(p, l, 500, 0, 0, calc(0, p, l, 500));
		$display("test schedule select done");
		xfer(1'b1, ign_timing_pkg::REG_CTRL, 32'h0, 4'hf, q);
		run(1023 - p, l, 0, 0, 0, calc(0, p, l, 0));
		$display("test knob lock done");
		wrap_up();
	end
endmodule : ignition_timing_angle_calc_tb
